//--- rtl/smph_pkg.sv
// Constants, types and register map of the mode page handler
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package smph_pkg;
   localparam logic [7:0] OP_SELECT    = 8'h15;
   localparam logic [7:0] OP_SENSE     = 8'h1a;
   localparam logic [5:0] PG_IGNORE    = 6'h00;
   localparam logic [5:0] PG_LAMP      = 6'h3d;
   localparam logic [5:0] PG_SEP       = 6'h3e;
   localparam logic [7:0] LAMP_DEFAULT = 8'h3c;   // 60 seconds
   localparam logic [7:0] SEP_REPORT   = 8'h80;
   localparam logic [7:0] SEP_QUIET    = 8'h00;
   localparam logic [3:0] SK_NONE      = 4'h0;
   localparam logic [3:0] SK_ILLEGAL   = 4'h5;
   localparam logic [4:0] ST_GOOD      = 5'h00;
   localparam logic [4:0] ST_CHECK     = 5'h01;
   localparam logic [7:0] MSG_COMPLETE = 8'h00;
   localparam logic [7:0] CDB_LAST     = 8'h05;
   localparam logic [7:0] PAGE_LEN     = 8'h01;
   localparam logic [7:0] SENSE_FULL   = 8'h07;   // Header plus page
   localparam logic [7:0] SENSE_HDR    = 8'h04;   // Header only
   localparam logic [7:0] PL_PAGE_IDX  = 8'h04;
   localparam logic [7:0] PL_PARM_IDX  = 8'h06;
   localparam int         OMIT_BIT     = 3;
   localparam int         PF_BIT       = 4;
   // Register byte addresses
   localparam logic [3:0] A_IRQ_STAT   = 4'h0;
   localparam logic [3:0] A_IRQ_MASK   = 4'h4;
   localparam logic [3:0] A_MODE       = 4'h8;
   localparam logic [3:0] A_CTRL       = 4'hc;
   localparam int         EV_DONE      = 0;
   localparam int         EV_CHECK     = 1;
   localparam int         EV_SEP       = 2;
   localparam logic [2:0] MASK_RESET   = 3'h0;
   localparam logic       CTRL_RESET   = 1'b1;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   typedef enum logic [7:0] {
      PH_IDLE  = 8'h01,
      PH_MSGO  = 8'h02,
      PH_CMD   = 8'h04,
      PH_DOUT  = 8'h08,
      PH_APPLY = 8'h10,
      PH_DIN   = 8'h20,
      PH_STAT  = 8'h40,
      PH_MSGI  = 8'h80
   } smph_phase_type;

   typedef struct packed {
      logic       sel;        // Selected by initiator
      logic       in_valid;   // Byte from initiator
      logic [7:0] in_byte;
      logic       out_ready;  // Initiator took out_byte
      logic       sep_sheet;  // Job sheet detected pulse
   } smph_link_in_type;

   typedef struct packed {
      logic           bsy;
      smph_phase_type phase;
      logic           in_ready;
      logic           out_valid;
      logic [7:0]     out_byte;
   } smph_link_out_type;
endpackage : smph_pkg

//--- rtl/smph_top.sv
// Mode page command handler with AXI4-Lite status and control
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module smph_top (
   input  wire logic                      aclk,          // 25 MHz clock
   input  wire logic                      aresetn,       // Sync reset
   input  wire logic                      s_awvalid,     // AXI write addr
   output logic                           s_awready,     // AXI write addr
   input  wire logic [3:0]                s_awaddr,      // AXI write addr
   input  wire logic                      s_wvalid,      // AXI write data
   output logic                           s_wready,      // AXI write data
   input  wire logic [31:0]               s_wdata,       // AXI write data
   input  wire logic [3:0]                s_wstrb,       // AXI byte lanes
   output logic                           s_bvalid,      // AXI response
   input  wire logic                      s_bready,      // AXI response
   output logic [1:0]                     s_bresp,       // AXI response
   input  wire logic                      s_arvalid,     // AXI read addr
   output logic                           s_arready,     // AXI read addr
   input  wire logic [3:0]                s_araddr,      // AXI read addr
   output logic                           s_rvalid,      // AXI read data
   input  wire logic                      s_rready,      // AXI read data
   output logic [31:0]                    s_rdata,       // AXI read data
   output logic [1:0]                     s_rresp,       // AXI read resp
   input  wire smph_pkg::smph_link_in_type  link_in,     // From bus engine
   output smph_pkg::smph_link_out_type      link_out,    // To bus engine
   output logic [7:0]                     lamp_seconds,  // Lamp on time
   output logic                           irq            // Level interrupt
);
   smph_pkg::smph_phase_type st_q, st_d;
   logic [7:0]  cnt_q, cnt_d, len_q, len_d;
   logic [7:0]  cdb_q [0:4];
   logic [7:0]  pl_q  [0:6];
   logic [5:0]  pg_q, pg_d;
   logic        chk_q, chk_d;
   logic [3:0]  sk_q, sk_d;
   logic [7:0]  lamp_q;
   logic        sep_q, sep_pend_q;
   logic [7:0]  out_byte_q;
   logic        bsy_q, en_q;
   logic [2:0]  stat_q, mask_q, ev;
   logic        aw_q, w_q;
   logic [3:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic        wlane_q;
   logic        in_take, out_take, eval, wr_go;
   // Stored page parameter as reported by the sense page
   function automatic logic [7:0] page_param(input logic [5:0] pg, input logic [7:0] lamp,
                                             input logic sep);
      page_param = (pg == smph_pkg::PG_LAMP) ? lamp :
                   (sep ? smph_pkg::SEP_REPORT : smph_pkg::SEP_QUIET);
   endfunction : page_param
   // Byte idx of returned mode data: header then page, no descriptor
   function automatic logic [7:0] sense_byte(input logic [7:0] idx, input logic [5:0] pg,
                                             input logic [7:0] lamp, input logic sep);
      logic [7:0] total;
      total = (pg == smph_pkg::PG_IGNORE) ? smph_pkg::SENSE_HDR : smph_pkg::SENSE_FULL;
      case (idx)
         8'h00:   sense_byte = total - 8'h01;
         8'h04:   sense_byte = {2'b00, pg};
         8'h05:   sense_byte = smph_pkg::PAGE_LEN;
         8'h06:   sense_byte = page_param(pg, lamp, sep);
         default: sense_byte = 8'h00;
      endcase
   endfunction : sense_byte
   //----------------------------------------------------------------
   // Command sequencer
   //----------------------------------------------------------------
   assign in_take  = link_in.in_valid && link_out.in_ready;
   assign out_take = link_out.out_valid && link_in.out_ready;
   assign eval     = (st_q == smph_pkg::PH_CMD) && in_take && (cnt_q == smph_pkg::CDB_LAST);
   // Next phase; CDB bytes 0..4 are already stored when the last byte arrives
   always_comb begin
      logic [5:0] pg;
      logic [7:0] total;
      pg    = cdb_q[2][5:0];
      total = (pg == smph_pkg::PG_IGNORE) ? smph_pkg::SENSE_HDR : smph_pkg::SENSE_FULL;
      st_d  = st_q;
      cnt_d = cnt_q;
      len_d = len_q;
      pg_d  = pg_q;
      chk_d = chk_q;
      sk_d  = sk_q;
      case (st_q)
         smph_pkg::PH_IDLE: begin
            if (link_in.sel && en_q) begin
               st_d  = smph_pkg::PH_MSGO;
               chk_d = 1'b0;
            end
         end
         smph_pkg::PH_MSGO: begin
            if (in_take) begin
               st_d  = smph_pkg::PH_CMD;
               cnt_d = 8'h00;
            end
         end
         smph_pkg::PH_CMD: begin
            if (in_take) begin
               cnt_d = cnt_q + 8'h01;
            end
            if (eval) begin
               cnt_d = 8'h00;
               pg_d  = pg;
               sk_d  = smph_pkg::SK_NONE;
               chk_d = sep_pend_q;
               st_d  = smph_pkg::PH_STAT;
               if (cdb_q[0] == smph_pkg::OP_SENSE) begin
                  if (cdb_q[2][7:6] != 2'b00 ||
                      !(pg == smph_pkg::PG_IGNORE || pg == smph_pkg::PG_LAMP ||
                        pg == smph_pkg::PG_SEP)) begin
                     chk_d = 1'b1;
                     sk_d  = smph_pkg::SK_ILLEGAL;
                  end else if (cdb_q[4] != 8'h00) begin
                     st_d  = smph_pkg::PH_DIN;
                     len_d = (cdb_q[4] < total) ? cdb_q[4] : total;
                  end
               end else if (cdb_q[0] == smph_pkg::OP_SELECT) begin
                  if (!cdb_q[1][smph_pkg::PF_BIT]) begin
                     chk_d = 1'b1;
                     sk_d  = smph_pkg::SK_ILLEGAL;
                  end else if (cdb_q[4] != 8'h00) begin
                     st_d  = smph_pkg::PH_DOUT;
                     len_d = cdb_q[4];
                  end
               end else begin
                  chk_d = 1'b1;
                  sk_d  = smph_pkg::SK_ILLEGAL;
               end
            end
         end
         smph_pkg::PH_DOUT: begin
            if (in_take) begin
               cnt_d = cnt_q + 8'h01;
               if (cnt_q == len_q - 8'h01) begin
                  st_d = smph_pkg::PH_APPLY;
               end
            end
         end
         smph_pkg::PH_APPLY: begin
            st_d = smph_pkg::PH_STAT;
            // A short list without the parameter byte changes nothing
            if (len_q > smph_pkg::PL_PARM_IDX &&
                !(pl_q[4][5:0] == smph_pkg::PG_IGNORE || pl_q[4][5:0] == smph_pkg::PG_LAMP ||
                  pl_q[4][5:0] == smph_pkg::PG_SEP)) begin
               chk_d = 1'b1;
               sk_d  = smph_pkg::SK_ILLEGAL;
            end
         end
         smph_pkg::PH_DIN: begin
            if (out_take) begin
               cnt_d = cnt_q + 8'h01;
               if (cnt_q == len_q - 8'h01) begin
                  st_d = smph_pkg::PH_STAT;
               end
            end
         end
         smph_pkg::PH_STAT: begin
            if (out_take) begin
               st_d = smph_pkg::PH_MSGI;
            end
         end
         smph_pkg::PH_MSGI: begin
            if (out_take) begin
               st_d = smph_pkg::PH_IDLE;
            end
         end
         default: st_d = smph_pkg::PH_IDLE;
      endcase
   end
   // Phase state and transfer counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q  <= smph_pkg::PH_IDLE;
         cnt_q <= 8'h00;
         len_q <= 8'h00;
         pg_q  <= smph_pkg::PG_IGNORE;
         chk_q <= 1'b0;
         sk_q  <= smph_pkg::SK_NONE;
         bsy_q <= 1'b0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         len_q <= len_d;
         pg_q  <= pg_d;
         chk_q <= chk_d;
         sk_q  <= sk_d;
         bsy_q <= (st_d != smph_pkg::PH_IDLE);
      end
   end
   // Captured CDB and parameter list bytes; only the first five CDB and first seven list bytes matter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 5; i++) cdb_q[i] <= 8'h00;
         for (int i = 0; i < 7; i++) pl_q[i] <= 8'h00;
      end else if (in_take) begin
         if (st_q == smph_pkg::PH_CMD && cnt_q < smph_pkg::CDB_LAST) begin
            cdb_q[cnt_q[2:0]] <= link_in.in_byte;
         end
         if (st_q == smph_pkg::PH_DOUT && cnt_q <= smph_pkg::PL_PARM_IDX) begin
            pl_q[cnt_q[2:0]] <= link_in.in_byte;
         end
      end
   end
   // Stored pages; the omit bit needs no action since no descriptor is ever sent
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lamp_q <= 8'h00;
         sep_q  <= 1'b0;
      end else if (st_q == smph_pkg::PH_APPLY && len_q > smph_pkg::PL_PARM_IDX) begin
         if (pl_q[4][5:0] == smph_pkg::PG_LAMP) begin
            lamp_q <= pl_q[6];
         end else if (pl_q[4][5:0] == smph_pkg::PG_SEP) begin
            if (pl_q[6] == smph_pkg::SEP_REPORT) sep_q <= 1'b1;
            else if (pl_q[6] == smph_pkg::SEP_QUIET) sep_q <= 1'b0;
         end
      end
   end
   // Pending job sheet report; a new sheet beats the clear at evaluation
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sep_pend_q <= 1'b0;
      end else if (link_in.sep_sheet && sep_q) begin
         sep_pend_q <= 1'b1;
      end else if (eval) begin
         sep_pend_q <= 1'b0;
      end
   end
   // Outgoing byte is prepared for the phase being entered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_byte_q <= 8'h00;
      end else begin
         case (st_d)
            smph_pkg::PH_DIN:  out_byte_q <= sense_byte(cnt_d, pg_d, lamp_q, sep_q);
            smph_pkg::PH_STAT: out_byte_q <= {2'b00, chk_d ? smph_pkg::ST_CHECK
                                                          : smph_pkg::ST_GOOD, 1'b0};
            smph_pkg::PH_MSGI: out_byte_q <= smph_pkg::MSG_COMPLETE;
            default:           out_byte_q <= 8'h00;
         endcase
      end
   end
   assign lamp_seconds       = (lamp_q == 8'h00) ? smph_pkg::LAMP_DEFAULT : lamp_q;
   assign link_out.bsy       = bsy_q;
   assign link_out.phase     = st_q;
   assign link_out.in_ready  = (st_q == smph_pkg::PH_MSGO) || (st_q == smph_pkg::PH_CMD) ||
                               (st_q == smph_pkg::PH_DOUT);
   assign link_out.out_valid = (st_q == smph_pkg::PH_DIN) || (st_q == smph_pkg::PH_STAT) ||
                               (st_q == smph_pkg::PH_MSGI);
   assign link_out.out_byte  = out_byte_q;

   //----------------------------------------------------------------
   // Interrupts and AXI4-Lite slave
   //----------------------------------------------------------------
   assign ev[smph_pkg::EV_DONE]  = (st_q == smph_pkg::PH_MSGI) && out_take;
   assign ev[smph_pkg::EV_CHECK] = (st_q != smph_pkg::PH_STAT) &&
                                   (st_d == smph_pkg::PH_STAT) && chk_d;
   assign ev[smph_pkg::EV_SEP]   = link_in.sep_sheet;
   assign irq   = |(stat_q & mask_q);
   assign wr_go = aw_q && w_q && !s_bvalid;
   // Sticky status, write one to clear; a same-cycle event stays set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= 3'h0;
      end else if (wr_go && wlane_q && awaddr_q == smph_pkg::A_IRQ_STAT) begin
         stat_q <= (stat_q & ~wdata_q[2:0]) | ev;
      end else begin
         stat_q <= stat_q | ev;
      end
   end

   // Write address and data are taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q  <= 32'h0;
         wlane_q  <= 1'b0;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_awaddr;
         end else if (wr_go) begin
            aw_q <= 1'b0;
         end
         if (s_wvalid && s_wready) begin
            w_q     <= 1'b1;
            wdata_q <= s_wdata;
            wlane_q <= s_wstrb[0];
         end else if (wr_go) begin
            w_q <= 1'b0;
         end
      end
   end

   // Writable registers and write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_q   <= smph_pkg::MASK_RESET;
         en_q     <= smph_pkg::CTRL_RESET;
         s_bvalid <= 1'b0;
         s_bresp  <= smph_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_bvalid <= 1'b1;
         s_bresp  <= (awaddr_q[1:0] != 2'b00) ? smph_pkg::RESP_SLVERR : smph_pkg::RESP_OKAY;
         if (wlane_q && awaddr_q == smph_pkg::A_IRQ_MASK) mask_q <= wdata_q[2:0];
         if (wlane_q && awaddr_q == smph_pkg::A_CTRL) en_q <= wdata_q[0];
      end else if (s_bready) begin
         s_bvalid <= 1'b0;
      end
   end

   assign s_awready = !aw_q && !s_bvalid;
   assign s_wready  = !w_q && !s_bvalid;
   assign s_arready = !s_rvalid;

   // Read data: mode state shows lamp, report enable, sense key, status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_rvalid <= 1'b0;
         s_rdata  <= 32'h0;
         s_rresp  <= smph_pkg::RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_rvalid <= 1'b1;
         s_rresp  <= smph_pkg::RESP_OKAY;
         case (s_araddr)
            smph_pkg::A_IRQ_STAT: s_rdata <= {29'h0, stat_q};
            smph_pkg::A_IRQ_MASK: s_rdata <= {29'h0, mask_q};
            smph_pkg::A_MODE:     s_rdata <= {15'h0, chk_q, sk_q, 3'h0, sep_q, lamp_q};
            smph_pkg::A_CTRL:     s_rdata <= {31'h0, en_q};
            default: begin
               s_rdata <= 32'h0;
               s_rresp <= smph_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_rready) begin
         s_rvalid <= 1'b0;
      end
   end
endmodule : smph_top
`default_nettype wire

//--- tb/smph_initiator.sv
// Initiator model on the link side of the handler
`timescale 1ns/1ps
`default_nettype none
module smph_initiator (
   input wire smph_pkg::smph_link_out_type lo,    // From target
   input wire logic                        aclk,  // Clock
   output var smph_pkg::smph_link_in_type  li     // To target
);
   //--------------------
   // Transfers
   //--------------------
   logic slow; // Idle cycle between bytes
   initial begin
      li = '0;
      slow = 1'b0;
   end
   // Select, then feed bytes out and collect bytes in until command complete
   task automatic xfer(input logic [7:0] q[$], output logic [7:0] got[$]);
      int k;
      logic tin, tout, bs, gap, nx;
      logic [7:0] b;
      smph_pkg::smph_phase_type ph;
      k = 0;
      gap = 1'b0;
      got = {};
      li.sel <= 1'b1;
      for (int n = 0; n < 150; n++) begin
         @(negedge aclk);
         tin = li.in_valid && lo.in_ready;
         tout = li.out_ready && lo.out_valid;
         b = lo.out_byte;
         bs = lo.bsy;
         ph = lo.phase;
         @(posedge aclk);
         gap = slow && !gap;
         if (bs) li.sel <= 1'b0;
         if (tin) k++;
         if (tout) got.push_back(b);
         // A released data line toggles, so a stale byte is never read as valid
         if (!li.in_valid || tin) begin
            nx = !gap && k < q.size() && ph inside {smph_pkg::PH_MSGO, smph_pkg::PH_CMD,
                                                     smph_pkg::PH_DOUT};
            li.in_valid <= nx;
            li.in_byte <= nx ? q[k] : ~li.in_byte;
         end
         if (!li.out_ready || tout)
            li.out_ready <= !gap && !(tout && ph == smph_pkg::PH_MSGI) &&
                            ph inside {smph_pkg::PH_DIN, smph_pkg::PH_STAT, smph_pkg::PH_MSGI};
         if (tout && ph == smph_pkg::PH_MSGI) break;
      end
   endtask : xfer
   task automatic sheet();
      li.sep_sheet <= 1'b1;
      @(posedge aclk);
      li.sep_sheet <= 1'b0;
   endtask : sheet
endmodule : smph_initiator
`default_nettype wire

//--- tb/smph_top_chk.sv
// Port assertions for the mode page handler
`timescale 1ns/1ps
`default_nettype none
module smph_top_chk (
   input wire logic                        aclk,         // Clock
   input wire logic                        aresetn,      // Sync reset
   input wire smph_pkg::smph_link_in_type  link_in,      // From initiator
   input wire smph_pkg::smph_link_out_type link_out,     // To initiator
   input wire logic [7:0]                  lamp_seconds  // Lamp time
);
   //--------------------
   // Helper counts
   //--------------------
   wire smph_pkg::smph_phase_type ph = link_out.phase;
   wire logic       it = link_in.in_valid && link_out.in_ready;
   wire logic       ov = link_out.out_valid;
   wire logic       ot = ov && link_in.out_ready;
   wire logic [7:0] ob = link_out.out_byte;
   logic [2:0]      idx_q;   // CDB byte index
   logic [7:0]      alloc_q; // Allocation length seen
   logic [7:0]      cnt_q;   // Data bytes sent
   // Idle restarts the counts, so a stale length never leaks into the next command
   always_ff @(posedge aclk) begin
      if (!aresetn || ph == smph_pkg::PH_IDLE) begin
         idx_q <= 3'h0;
         cnt_q <= 8'h00;
      end else begin
         if (ph == smph_pkg::PH_CMD && it) idx_q <= idx_q + 3'h1;
         if (ph == smph_pkg::PH_CMD && it && idx_q == 3'h4) alloc_q <= link_in.in_byte;
         if (ph == smph_pkg::PH_DIN && ot) cnt_q <= cnt_q + 8'h01;
      end
   end
   //--------------------
   // Assertions
   //--------------------
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_bsy_start: assert property ($rose(link_out.bsy) |-> ph == smph_pkg::PH_MSGO)
      else $error("busy rose outside message out");
   a_bsy_release: assert property (ph == smph_pkg::PH_MSGI && ot |=> !link_out.bsy && ph == smph_pkg::PH_IDLE)
      else $error("busy held after command complete");
   a_status_next: assert property (ph == smph_pkg::PH_STAT && ot |=> ph == smph_pkg::PH_MSGI)
      else $error("no message after status byte");
   a_status_code: assert property (ph == smph_pkg::PH_STAT && ov |-> ob inside {8'h00, 8'h02})
      else $error("bad status code");
   a_msg_done: assert property (ph == smph_pkg::PH_MSGI && ov |-> ob == smph_pkg::MSG_COMPLETE)
      else $error("bad completion message");
   a_din_alloc: assert property (ph == smph_pkg::PH_DIN && ov |-> cnt_q < alloc_q && cnt_q < smph_pkg::SENSE_FULL)
      else $error("data sent past its limit");
   a_hdr_len: assert property (ph == smph_pkg::PH_DIN && ov && cnt_q == 8'h00 |-> ob inside {8'h06, 8'h03})
      else $error("bad mode data length");
   a_desc_zero: assert property (ph == smph_pkg::PH_DIN && ov && cnt_q == 8'h03 |-> ob == 8'h00)
      else $error("descriptor length not zero");
   a_out_hold: assert property (ov && !link_in.out_ready |=> ov && $stable(ob))
      else $error("offered byte dropped");
   a_lamp_floor: assert property (lamp_seconds != 8'h00)
      else $error("lamp time zero");
   a_lamp_apply: assert property ($changed(lamp_seconds) |-> $past(ph) == smph_pkg::PH_APPLY)
      else $error("lamp time changed outside apply");
   c_sense: cover property (ph == smph_pkg::PH_DIN && ot);
   c_check: cover property (ph == smph_pkg::PH_STAT && ov && ob == 8'h02);
   c_apply: cover property (ph == smph_pkg::PH_APPLY);
endmodule : smph_top_chk
bind smph_top smph_top_chk smph_top_chk_i (.aclk, .aresetn, .link_in, .link_out, .lamp_seconds);
`default_nettype wire

//--- tb/test_scsi_mode_page_handler.sv
// Self-checking bench for the mode page handler
`timescale 1ns/1ps
`default_nettype none
module test_scsi_mode_page_handler;
   logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
   logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
   logic [3:0]  s_awaddr, s_araddr, s_wstrb;
   logic [31:0] s_wdata, s_rdata, v;
   logic [1:0]  s_bresp, s_rresp, r;
   logic [7:0]  lamp_seconds, got[$], exp_pg[$];
   int          err_total, checks_done, cyc;
   smph_pkg::smph_link_in_type  link_in;
   smph_pkg::smph_link_out_type link_out;
   localparam logic [7:0] good = {2'b00, smph_pkg::ST_GOOD, 1'b0};
   localparam logic [7:0] chk = {2'b00, smph_pkg::ST_CHECK, 1'b0};
   smph_top smph_top_i (.aclk, .aresetn, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid,
      .s_wready, .s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready,
      .s_araddr, .s_rvalid, .s_rready, .s_rdata, .s_rresp, .link_in, .link_out,
      .lamp_seconds, .irq);
   smph_initiator smph_initiator_i (.lo(link_out), .aclk, .li(link_in));
   //--------------------
   // Tasks
   //--------------------
   always #20 aclk = ~aclk;
   // A hang ends in the same report as a normal run
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out
   task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] sn);
      checks_done++;
      if (sn !== ex) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, ex, sn);
      end
   endtask : cmp
   // One register access; each channel is released on its own handshake
   task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d);
      logic ta, tw, tr;
      s_awvalid <= w;
      s_wvalid <= w;
      s_bready <= w;
      s_arvalid <= !w;
      s_rready <= !w;
      s_awaddr <= a;
      s_araddr <= a;
      s_wdata <= d;
      forever begin
         @(negedge aclk);
         ta = (s_awready && s_awvalid) || (s_arready && s_arvalid);
         tw = s_wready && s_wvalid;
         tr = w ? s_bvalid : s_rvalid;
         r = w ? s_bresp : s_rresp;
         v = s_rdata;
         @(posedge aclk);
         if (ta) s_awvalid <= 1'b0;
         if (ta) s_arvalid <= 1'b0;
         if (tw) s_wvalid <= 1'b0;
         if (tr) s_bready <= 1'b0;
         if (tr) s_rready <= 1'b0;
         if (tr) break;
      end
      // Let an edge pass so a following call never retoggles a released line
      @(posedge aclk);
   endtask : axi
   task automatic run(input logic [7:0] q[$], input logic [7:0] st, input int nd);
      smph_initiator_i.xfer(q, got);
      cmp("status", st, got[got.size()-2]);
      cmp("message", smph_pkg::MSG_COMPLETE, got[got.size()-1]);
      cmp("data count", nd, got.size() - 2);
      @(negedge aclk);
      cmp("busy", 1'b0, link_out.bsy);
      @(posedge aclk);
   endtask : run
   task automatic sense(input logic [7:0] b1, b2, al, st, input int nd);
      run({8'h80, smph_pkg::OP_SENSE, b1, b2, 8'h00, al, 8'h00}, st, nd);
   endtask : sense
   task automatic sel(input logic [7:0] b1, pg, prm, ln, st);
      logic [7:0] q[$];
      q = {8'h80, smph_pkg::OP_SELECT, b1, 8'h00, 8'h00, ln, 8'h00, 8'h00, 8'h00, 8'h00,
           8'h00, pg, smph_pkg::PAGE_LEN, prm};
      if (ln == 8'h00) q = q[0:6];
      run(q, st, 0);
   endtask : sel
   //--------------------
   // Tests
   //--------------------
   initial begin
      {aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      {s_awaddr, s_araddr, s_wdata} = '0;
      s_wstrb = 4'hf;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      cmp("lamp reset", 8'h3c, lamp_seconds);
      axi(0, smph_pkg::A_CTRL, 0);
      cmp("ctrl reset", 32'h1, v);
      axi(1, smph_pkg::A_IRQ_MASK, 32'h7);
      sel(8'h10, 8'h3d, 8'h2d, 8'h07, good);
      cmp("lamp set", 8'h2d, lamp_seconds);
      cmp("irq up", 1'b1, irq);
      smph_initiator_i.slow = 1'b1;
      sense(8'h00, 8'h3d, 8'hff, good, 7);
      smph_initiator_i.slow = 1'b0;
      exp_pg = {8'h06, 8'h00, 8'h00, 8'h00, 8'h3d, 8'h01, 8'h2d};
      foreach (exp_pg[i]) cmp("mode byte", exp_pg[i], got[i]);
      sense(8'h08, 8'h3d, 8'h03, good, 3);
      cmp("length byte", 8'h06, got[0]);
      sense(8'h00, 8'h3d, 8'h00, good, 0);
      sense(8'h00, 8'h00, 8'hff, good, 4);
      cmp("header only", 8'h03, got[0]);
      for (int pc = 1; pc < 4; pc++) sense(8'h00, {pc[1:0], 6'h3d}, 8'hff, chk, 0);
      axi(0, smph_pkg::A_MODE, 0);
      cmp("sense key", {1'b1, smph_pkg::SK_ILLEGAL}, v[16:12]);
      foreach (exp_pg[i]) exp_pg[i] = 8'h00;
      exp_pg = {8'h01, 8'h02, 8'h03, 8'h04, 8'h3c, 8'h3f};
      foreach (exp_pg[i]) sense(8'h00, exp_pg[i], 8'hff, chk, 0);
      sel(8'h10, 8'h3f, 8'h11, 8'h07, chk);
      cmp("lamp kept", 8'h2d, lamp_seconds);
      sel(8'h00, 8'h3d, 8'h00, 8'h00, chk);
      sel(8'h10, 8'h3d, 8'h00, 8'h07, good);
      cmp("lamp default", smph_pkg::LAMP_DEFAULT, lamp_seconds);
      sel(8'h10, 8'h3e, smph_pkg::SEP_REPORT, 8'h07, good);
      smph_initiator_i.sheet();
      sense(8'h00, 8'h3d, 8'hff, chk, 7);
      sel(8'h10, 8'h3e, smph_pkg::SEP_QUIET, 8'h07, good);
      smph_initiator_i.sheet();
      sense(8'h00, 8'h00, 8'hff, good, 4);
      axi(0, smph_pkg::A_IRQ_STAT, 0);
      cmp("irq status", 32'h7, v);
      axi(1, smph_pkg::A_IRQ_STAT, 32'h7);
      cmp("irq cleared", 1'b0, irq);
      axi(1, smph_pkg::A_IRQ_MASK, 32'h0);
      sense(8'h00, 8'h3d, 8'hff, good, 7);
      cmp("irq masked", 1'b0, irq);
      axi(0, 4'h2, 0);
      cmp("read unaligned", smph_pkg::RESP_SLVERR, r);
      axi(1, 4'h1, 0);
      cmp("write unaligned", smph_pkg::RESP_SLVERR, r);
      close_out();
   end
endmodule : test_scsi_mode_page_handler
`default_nettype wire
